// ==== rtl/bmscc_pkg.sv ====
// Shared constants and types for the boot mode, status pin and clock setup block.
// Assumes a single 50 MHz clock domain and a word-aligned register port.
package bmscc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_FREQ = 4'h8;

    // Control word field positions
    localparam int unsigned CTRL_FUNC_LSB = 0;
    localparam int unsigned CTRL_GPO_BIT = 2;
    localparam int unsigned CTRL_DBL_BIT = 3;
    localparam int unsigned CTRL_SPR_LSB = 4;
    localparam int unsigned CTRL_SYNC_BIT = 6;

    // Status word field positions
    localparam int unsigned STAT_DOWNLOAD_CONNECTOR_BIT = 0;
    localparam int unsigned STAT_RUN_BIT = 1;
    localparam int unsigned STAT_LOAD_BIT = 2;
    localparam int unsigned STAT_PINS_LSB = 3;
    localparam int unsigned STAT_SCLK_BIT = 5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_FETCH = 2'h0,
        ST_INTACK = 2'h1,
        ST_GPO = 2'h2
    } bmscc_stfunc_t;

    typedef enum logic [1:0] {
        SPR_OFF = 2'h0,
        SPR_NORMAL = 2'h1,
        SPR_STRONG = 2'h2
    } bmscc_spread_t;

    typedef enum logic [4:0] {
        S_RESET = 5'h01,
        S_SAMPLE = 5'h02,
        S_RUN = 5'h04,
        S_PROGWAIT = 5'h08,
        S_PROGRUN = 5'h10
    } bmscc_state_t;

    typedef struct packed {
        logic serial_sync;
        bmscc_spread_t spread;
        logic doubler_en;
        logic gpo_level;
        bmscc_stfunc_t func;
    } bmscc_cfg_t;

    localparam bmscc_cfg_t CFG_RST = '{serial_sync: 1'b0, spread: SPR_NORMAL,
        doubler_en: 1'b1, gpo_level: 1'b1, func: ST_FETCH};

    // ------------------------------------------------------------
    // Boot and timing
    // ------------------------------------------------------------
    localparam logic [1:0] PINS_PROGRAM = 2'h3;
    localparam logic [15:0] RUN_START_ADDR = 16'h0000;
    localparam logic [15:0] RES_KHZ = 16'h2B34;
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned RST_HOLD_NS = 1000;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SETTLE_CYC = 3;

endpackage : bmscc_pkg

// ==== rtl/bmscc_sync.sv ====
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are static levels; no pulse capture.
`timescale 1ns/1ps
module bmscc_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] lvl
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= RST_VAL;
            lvl <= RST_VAL;
        end else begin
            meta_q <= pin;
            lvl <= meta_q;
        end
    end

endmodule : bmscc_sync

// ==== rtl/bmscc_top.sv ====
// Boot mode sequencer, status pin, external reset and clock setup.
// Assumes a 50 MHz clk, a register port master and raw pins from the connector.
//
// Overview of operation
// - Both boot select pins high at reset give program mode and a cold boot; low gives run mode.
// - In run mode execution starts at address zero once reset is released, with no download.
// - In fetch mode the status pin goes low during the first opcode fetch of each instruction.
// - In interrupt mode the status pin goes low during each interrupt acknowledge cycle.
// - In output mode the status pin shows the level that software last wrote.
// - The external reset input forces a hard reset of the processor and the peripheral logic.
// - With the doubler on, the system clock is twice the resonator frequency.
// - The doubler is on after reset and software can turn it off, leaving the resonator rate.
// - The spreader has off, normal and strong settings 0, 1 and 2, with normal after reset.
// - The serial port runs clocked, or asynchronous with its clock line read as an input.
// - Once running, the boot select pins read as inputs and the status pin acts as an output.
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module bmscc_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire logic [1:0] boot_select_pins,
    input wire logic reset_in_b,
    input wire logic serial_clk_pin,
    input wire logic cpu_first_fetch,
    input wire logic cpu_int_ack,
    input wire logic boot_load_done,
    output logic status_pin,
    output logic cpu_reset_b,
    output logic periph_reset_b,
    output logic cpu_run,
    output logic [15:0] cpu_start_addr,
    output logic boot_load_req,
    output logic program_mode,
    output logic doubler_en,
    output logic [1:0] spread_setting,
    output logic serial_sync_mode
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins_s;
    logic [1:0] boot_pins_s;
    logic reset_in_s;
    logic sclk_s;

    bmscc_sync #(
        .W(4),
        .RST_VAL(4'h4)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin({serial_clk_pin, reset_in_b, boot_select_pins}),
        .lvl(pins_s)
    );

    assign boot_pins_s = pins_s[1:0];
    assign reset_in_s = pins_s[2];
    assign sclk_s = pins_s[3];

    // ------------------------------------------------------------
    // External hard reset with stretch
    // ------------------------------------------------------------
    logic ext_rst;
    logic hard_rst;
    logic [5:0] hold_q;

    assign ext_rst = !reset_in_s;

    // Stretch so a bouncing button still yields one clean reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= 6'h00;
        end else if (ext_rst) begin
            hold_q <= 6'(bmscc_pkg::RST_HOLD_CYC);
        end else if (hold_q != 6'h00) begin
            hold_q <= hold_q - 6'h01;
        end
    end

    assign hard_rst = ext_rst || (hold_q != 6'h00);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            periph_reset_b <= 1'b0;
        end else begin
            periph_reset_b <= !hard_rst;
        end
    end

    // ------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------
    bmscc_pkg::bmscc_state_t state_q;
    logic [1:0] settle_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= bmscc_pkg::S_RESET;
        end else if (hard_rst) begin
            state_q <= bmscc_pkg::S_RESET;
        end else begin
            case (state_q)
                bmscc_pkg::S_RESET: begin
                    if (settle_q == 2'(bmscc_pkg::SETTLE_CYC)) begin
                        state_q <= bmscc_pkg::S_SAMPLE;
                    end
                end
                bmscc_pkg::S_SAMPLE: begin
                    // Mixed pin levels are not a program request
                    if (boot_pins_s == bmscc_pkg::PINS_PROGRAM) begin
                        state_q <= bmscc_pkg::S_PROGWAIT;
                    end else begin
                        state_q <= bmscc_pkg::S_RUN;
                    end
                end
                bmscc_pkg::S_PROGWAIT: begin
                    if (boot_load_done) begin
                        state_q <= bmscc_pkg::S_PROGRUN;
                    end
                end
                bmscc_pkg::S_RUN: state_q <= bmscc_pkg::S_RUN;
                bmscc_pkg::S_PROGRUN: state_q <= bmscc_pkg::S_PROGRUN;
                default: state_q <= bmscc_pkg::S_RESET;
            endcase
        end
    end

    // Waits for the synchroniser to carry real pin levels
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_q <= 2'h0;
        end else if (hard_rst || state_q != bmscc_pkg::S_RESET) begin
            settle_q <= 2'h0;
        end else if (settle_q != 2'(bmscc_pkg::SETTLE_CYC)) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            program_mode <= 1'b0;
        end else if (state_q == bmscc_pkg::S_SAMPLE) begin
            program_mode <= (boot_pins_s == bmscc_pkg::PINS_PROGRAM);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_reset_b <= 1'b0;
            cpu_run <= 1'b0;
            boot_load_req <= 1'b0;
            cpu_start_addr <= bmscc_pkg::RUN_START_ADDR;
        end else begin
            cpu_reset_b <= !hard_rst && state_q != bmscc_pkg::S_RESET
                && state_q != bmscc_pkg::S_SAMPLE;
            cpu_run <= !hard_rst && (state_q == bmscc_pkg::S_RUN
                || state_q == bmscc_pkg::S_PROGRUN);
            boot_load_req <= !hard_rst && state_q == bmscc_pkg::S_PROGWAIT;
            cpu_start_addr <= bmscc_pkg::RUN_START_ADDR;
        end
    end

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    bmscc_pkg::bmscc_cfg_t cfg_q;
    logic ctrl_wr;
    logic [1:0] wr_func;
    logic [1:0] wr_spr;

    assign ctrl_wr = reg_we && reg_addr == bmscc_pkg::ADDR_CTRL;
    assign wr_func = reg_wdata[bmscc_pkg::CTRL_FUNC_LSB +: 2];
    assign wr_spr = reg_wdata[bmscc_pkg::CTRL_SPR_LSB +: 2];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= bmscc_pkg::CFG_RST;
        end else if (hard_rst) begin
            cfg_q <= bmscc_pkg::CFG_RST;
        end else if (ctrl_wr) begin
            // Code 3 is not a function; old selection stays
            if (wr_func != 2'h3) begin
                cfg_q.func <= bmscc_pkg::bmscc_stfunc_t'(wr_func);
            end
            // Code 3 is not a setting; old setting stays
            if (wr_spr != 2'h3) begin
                cfg_q.spread <= bmscc_pkg::bmscc_spread_t'(wr_spr);
            end
            cfg_q.gpo_level <= reg_wdata[bmscc_pkg::CTRL_GPO_BIT];
            cfg_q.doubler_en <= reg_wdata[bmscc_pkg::CTRL_DBL_BIT];
            cfg_q.serial_sync <= reg_wdata[bmscc_pkg::CTRL_SYNC_BIT];
        end
    end

    assign doubler_en = cfg_q.doubler_en;
    assign spread_setting = cfg_q.spread;
    assign serial_sync_mode = cfg_q.serial_sync;

    // ------------------------------------------------------------
    // Status pin
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_pin <= 1'b1;
        end else begin
            case (cfg_q.func)
                bmscc_pkg::ST_FETCH: status_pin <= !cpu_first_fetch;
                bmscc_pkg::ST_INTACK: status_pin <= !cpu_int_ack;
                bmscc_pkg::ST_GPO: status_pin <= cfg_q.gpo_level;
                default: status_pin <= 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    logic [15:0] sys_khz;
    logic [31:0] stat_word;

    // Doubled rate is exact; 11060 kHz gives the nominal 22.1 MHz
    assign sys_khz = cfg_q.doubler_en ? 16'(bmscc_pkg::RES_KHZ << 1)
        : bmscc_pkg::RES_KHZ;

    always_comb begin
        stat_word = 32'h00000000;
        stat_word[bmscc_pkg::STAT_DOWNLOAD_CONNECTOR_BIT] = program_mode;
        stat_word[bmscc_pkg::STAT_RUN_BIT] = cpu_run;
        stat_word[bmscc_pkg::STAT_LOAD_BIT] = boot_load_req;
        stat_word[bmscc_pkg::STAT_PINS_LSB +: 2] = boot_pins_s;
        // Clock line is a plain input only in the asynchronous mode
        stat_word[bmscc_pkg::STAT_SCLK_BIT] = sclk_s && !cfg_q.serial_sync;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_re) begin
            case (reg_addr)
                bmscc_pkg::ADDR_CTRL: reg_rdata <= {25'h0000000, cfg_q};
                bmscc_pkg::ADDR_STAT: reg_rdata <= stat_word;
                bmscc_pkg::ADDR_FREQ: reg_rdata <= {16'h0000, sys_khz};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_download_connector_mode;
        @(posedge clk) disable iff (!rst_b)
        (state_q == bmscc_pkg::S_SAMPLE && !hard_rst && boot_pins_s == 2'h3)
            |=> program_mode ##1 boot_load_req && !cpu_run;
    endproperty
    a_download_connector_mode: assert property (p_download_connector_mode) else $error("program mode not entered");

    property p_run_mode;
        @(posedge clk) disable iff (!rst_b)
        (state_q == bmscc_pkg::S_SAMPLE && !hard_rst && boot_pins_s == 2'h0)
            |=> !program_mode ##1 cpu_run && !boot_load_req;
    endproperty
    a_run_mode: assert property (p_run_mode) else $error("run mode not entered");

    property p_run_addr;
        @(posedge clk) disable iff (!rst_b)
        $rose(cpu_run) |-> cpu_start_addr == 16'h0000 && cpu_reset_b;
    endproperty
    a_run_addr: assert property (p_run_addr) else $error("run start not at zero");

    property p_fetch;
        @(posedge clk) disable iff (!rst_b || hard_rst || ctrl_wr)
        (cfg_q.func == bmscc_pkg::ST_FETCH) |=> status_pin == !$past(cpu_first_fetch);
    endproperty
    a_fetch: assert property (p_fetch) else $error("status not low on fetch");

    property p_intack;
        @(posedge clk) disable iff (!rst_b || hard_rst || ctrl_wr)
        (cfg_q.func == bmscc_pkg::ST_INTACK) |=> status_pin == !$past(cpu_int_ack);
    endproperty
    a_intack: assert property (p_intack) else $error("status not low on int ack");

    property p_gpo;
        @(posedge clk) disable iff (!rst_b || hard_rst)
        (ctrl_wr && wr_func == 2'h2) |=> ##1 status_pin == $past(reg_wdata[2], 2);
    endproperty
    a_gpo: assert property (p_gpo) else $error("status not at written level");

    property p_ext_rst;
        @(posedge clk) disable iff (!rst_b)
        ext_rst |=> !periph_reset_b && !cpu_reset_b && !cpu_run ##1 cfg_q == bmscc_pkg::CFG_RST;
    endproperty
    a_ext_rst: assert property (p_ext_rst) else $error("external reset not honoured");

    property p_freq;
        @(posedge clk) disable iff (!rst_b)
        doubler_en |-> sys_khz == 16'(bmscc_pkg::RES_KHZ * 2);
    endproperty
    a_freq: assert property (p_freq) else $error("doubled rate wrong");

    property p_dbl_off;
        @(posedge clk) disable iff (!rst_b || hard_rst)
        (ctrl_wr && !reg_wdata[3]) |=> !doubler_en && sys_khz == bmscc_pkg::RES_KHZ;
    endproperty
    a_dbl_off: assert property (p_dbl_off) else $error("doubler not disabled");

    property p_spread;
        @(posedge clk) disable iff (!rst_b || hard_rst)
        (ctrl_wr && wr_spr == 2'h3) |=> $stable(spread_setting) && spread_setting != 2'h3;
    endproperty
    a_spread: assert property (p_spread) else $error("bad spread setting taken");

    property p_func;
        @(posedge clk) disable iff (!rst_b)
        cfg_q.func != 2'h3;
    endproperty
    a_func: assert property (p_func) else $error("no status function active");

    property p_sclk;
        @(posedge clk) disable iff (!rst_b)
        (reg_re && reg_addr == bmscc_pkg::ADDR_STAT && serial_sync_mode)
            |=> !reg_rdata[5];
    endproperty
    a_sclk: assert property (p_sclk) else $error("clock line read in clocked mode");

    c_download_connector: cover property (@(posedge clk) disable iff (!rst_b) $rose(boot_load_req));
    c_run: cover property (@(posedge clk) disable iff (!rst_b) $rose(cpu_run) && !program_mode);
    c_fetch: cover property (@(posedge clk) disable iff (!rst_b) $fell(status_pin) && cpu_run);
    c_extrst: cover property (@(posedge clk) disable iff (!rst_b) $rose(ext_rst) && cpu_run);
    c_intack: cover property (@(posedge clk) disable iff (!rst_b) $fell(status_pin) && cfg_q.func == bmscc_pkg::ST_INTACK);

endmodule : bmscc_top

// ==== sim/bmscc_host_model.sv ====
// Model of the programming cable on the download connector.
// Assumes the bench steers attach, reset and download through the inputs.
`timescale 1ns/1ps
module bmscc_host_model (
    input wire logic clk,
    input wire logic attach,
    input wire logic hold_reset,
    input wire logic clk_lvl,
    input wire logic load_go,
    input wire logic [7:0] load_wait,
    input wire logic boot_load_req,
    output logic [1:0] boot_select_pins,
    output logic reset_in_b,
    output logic serial_clk_pin,
    output logic boot_load_done
);
    logic [7:0] cnt_q = 8'h00;
    logic sent_q = 1'b0;
    logic done_q = 1'b0;

    // Cable pulls both pins high, absent cable leaves them low
    assign boot_select_pins = attach ? 2'h3 : 2'h0;
    assign reset_in_b = ~hold_reset;
    // Clock line as plain input level in the asynchronous use
    assign serial_clk_pin = clk_lvl;
    assign boot_load_done = done_q;

    // Download finishes after a chosen delay, one pulse each time load_go is raised
    always @(posedge clk) begin
        done_q <= 1'b0;
        if (!load_go) begin
            cnt_q <= 8'h00;
            sent_q <= 1'b0;
        end else if (boot_load_req && !sent_q) begin
            if (cnt_q == load_wait) begin
                done_q <= 1'b1;
                sent_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule : bmscc_host_model

// ==== sim/bmscc_top_tb.sv ====
// Self-checking bench for the boot mode, status pin and clock setup block.
// Assumes the cable model in bmscc_host_model and a 50 MHz clock.
`timescale 1ns/1ps
module bmscc_top_tb;
    logic clk = 1'b0;
    logic rst_b, reg_we, reg_re, cpu_first_fetch, cpu_int_ack, boot_load_done;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed;
    logic [1:0] boot_select_pins, spread_setting;
    logic reset_in_b, serial_clk_pin, status_pin, cpu_reset_b, periph_reset_b, cpu_run;
    logic [15:0] cpu_start_addr;
    logic boot_load_req, program_mode, doubler_en, serial_sync_mode;
    logic attach, hold_reset, clk_lvl, load_go, st_v, re_seen, st_seen;
    logic [31:0] rd_q[$];
    logic [31:0] st_q[$];
    int miscompares = 0;
    int cmp_count = 0;

    always #10 clk = ~clk;

    bmscc_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .boot_select_pins(boot_select_pins), .reset_in_b(reset_in_b),
        .serial_clk_pin(serial_clk_pin), .cpu_first_fetch(cpu_first_fetch), .cpu_int_ack(cpu_int_ack),
        .boot_load_done(boot_load_done), .status_pin(status_pin), .cpu_reset_b(cpu_reset_b),
        .periph_reset_b(periph_reset_b), .cpu_run(cpu_run), .cpu_start_addr(cpu_start_addr),
        .boot_load_req(boot_load_req), .program_mode(program_mode), .doubler_en(doubler_en),
        .spread_setting(spread_setting), .serial_sync_mode(serial_sync_mode));

    bmscc_host_model host (.clk(clk), .attach(attach), .hold_reset(hold_reset), .clk_lvl(clk_lvl),
        .load_go(load_go), .load_wait(8'h05), .boot_load_req(boot_load_req),
        .boot_select_pins(boot_select_pins), .reset_in_b(reset_in_b), .serial_clk_pin(serial_clk_pin),
        .boot_load_done(boot_load_done));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [31:0] ctrl_w(logic [1:0] fn, logic gpo, logic dbl, logic [1:0] spr, logic sy);
        ctrl_w = 32'h0;
        ctrl_w[bmscc_pkg::CTRL_FUNC_LSB +: 2] = fn;
        ctrl_w[bmscc_pkg::CTRL_GPO_BIT] = gpo;
        ctrl_w[bmscc_pkg::CTRL_DBL_BIT] = dbl;
        ctrl_w[bmscc_pkg::CTRL_SPR_LSB +: 2] = spr;
        ctrl_w[bmscc_pkg::CTRL_SYNC_BIT] = sy;
    endfunction : ctrl_w

    function automatic logic [31:0] stat_w(logic download_connector, logic run, logic ld, logic [1:0] pins, logic sc);
        stat_w = 32'h0;
        stat_w[bmscc_pkg::STAT_DOWNLOAD_CONNECTOR_BIT] = download_connector;
        stat_w[bmscc_pkg::STAT_RUN_BIT] = run;
        stat_w[bmscc_pkg::STAT_LOAD_BIT] = ld;
        stat_w[bmscc_pkg::STAT_PINS_LSB +: 2] = pins;
        stat_w[bmscc_pkg::STAT_SCLK_BIT] = sc;
    endfunction : stat_w

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr

    task automatic rd(logic [3:0] a, logic [31:0] exp);
        @(posedge clk);
        rd_q.push_back(exp);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
    endtask : rd

    // Random fetch and acknowledge traffic; mode 0 fetch, 1 acknowledge, 2 output
    task automatic stat_run(int n, int mode, logic lvl);
        logic f, a;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            seed = lfsr_next(seed);
            f = seed[0];
            a = seed[7];
            cpu_first_fetch <= f;
            cpu_int_ack <= a;
            st_q.push_back({31'h0, (mode == 0) ? ~f : (mode == 1) ? ~a : lvl});
            st_v <= 1'b1;
        end
        @(posedge clk);
        st_v <= 1'b0;
        cpu_first_fetch <= 1'b0;
        cpu_int_ack <= 1'b0;
    endtask : stat_run

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    always @(posedge clk) begin
        re_seen = reg_re;
        st_seen = st_v;
        #1;
        if (re_seen) chk("reg_rdata", reg_rdata, rd_q.pop_front());
        if (st_seen) chk("status_pin", {31'h0, status_pin}, st_q.pop_front());
    end

    // Long enough for all tests with a wide margin
    initial begin
        #(20 * 5000);
        miscompares++;
        summarize();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        seed = 32'h9579A557;
        rst_b = 1'b0;
        {reg_we, reg_re, cpu_first_fetch, cpu_int_ack, st_v, hold_reset, load_go, attach} = 8'h00;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        clk_lvl = 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk("cpu_run", {31'h0, cpu_run}, 32'h1);
        chk("cpu_reset_b", {31'h0, cpu_reset_b}, 32'h1);
        chk("periph_reset_b", {31'h0, periph_reset_b}, 32'h1);
        chk("program_mode", {31'h0, program_mode}, 32'h0);
        chk("cpu_start_addr", {16'h0, cpu_start_addr}, {16'h0, bmscc_pkg::RUN_START_ADDR});
        chk("doubler_en", {31'h0, doubler_en}, 32'h1);
        chk("spread_setting", {30'h0, spread_setting}, 32'h1);
        rd(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h0, 1'b1, 1'b1, 2'h1, 1'b0));
        rd(bmscc_pkg::ADDR_FREQ, 32'h00005668);
        rd(bmscc_pkg::ADDR_STAT, stat_w(1'b0, 1'b1, 1'b0, 2'h0, 1'b1));
        rd(4'hC, 32'h0);
        $display("test reset defaults and run mode done");

        stat_run(24, 0, 1'b1);
        wr(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h1, 1'b1, 1'b1, 2'h1, 1'b0));
        stat_run(24, 1, 1'b1);
        wr(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h2, 1'b0, 1'b1, 2'h1, 1'b0));
        stat_run(6, 2, 1'b0);
        // Code 3 must not disturb the held function; the level still lands
        wr(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h3, 1'b1, 1'b1, 2'h1, 1'b0));
        stat_run(6, 2, 1'b1);
        rd(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h2, 1'b1, 1'b1, 2'h1, 1'b0));
        $display("test status functions done");

        // Strong setting tried once here; real software avoids it
        for (int s = 0; s < 3; s++) begin
            wr(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h0, 1'b1, s[0], s[1:0], 1'b1));
            #1;
            chk("spread_setting", {30'h0, spread_setting}, s);
            chk("doubler_en", {31'h0, doubler_en}, {31'h0, s[0]});
            chk("serial_sync_mode", {31'h0, serial_sync_mode}, 32'h1);
            rd(bmscc_pkg::ADDR_FREQ, s[0] ? 32'h00005668 : 32'h00002B34);
        end
        rd(bmscc_pkg::ADDR_STAT, stat_w(1'b0, 1'b1, 1'b0, 2'h0, 1'b0));
        // Spread code 3 is refused; the strong setting must stay
        wr(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h0, 1'b1, 1'b0, 2'h3, 1'b1));
        wr(4'hC, 32'hFFFFFFFF);
        rd(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h0, 1'b1, 1'b0, 2'h2, 1'b1));
        $display("test clock and serial settings done");

        // Cable attached, host forces a hard reset; config returns to defaults
        attach <= 1'b1;
        hold_reset <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk("cpu_reset_b", {31'h0, cpu_reset_b}, 32'h0);
        chk("periph_reset_b", {31'h0, periph_reset_b}, 32'h0);
        chk("cpu_run", {31'h0, cpu_run}, 32'h0);
        wr(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h1, 1'b0, 1'b0, 2'h0, 1'b1));
        rd(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h0, 1'b1, 1'b1, 2'h1, 1'b0));
        hold_reset <= 1'b0;
        repeat (70) @(posedge clk);
        #1;
        chk("program_mode", {31'h0, program_mode}, 32'h1);
        chk("boot_load_req", {31'h0, boot_load_req}, 32'h1);
        chk("cpu_run", {31'h0, cpu_run}, 32'h0);
        chk("cpu_reset_b", {31'h0, cpu_reset_b}, 32'h1);
        rd(bmscc_pkg::ADDR_STAT, stat_w(1'b1, 1'b0, 1'b1, 2'h3, 1'b1));
        load_go <= 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk("cpu_run", {31'h0, cpu_run}, 32'h1);
        chk("boot_load_req", {31'h0, boot_load_req}, 32'h0);
        // Cable pulled while running: pins read live, mode stays latched
        @(posedge clk);
        attach <= 1'b0;
        clk_lvl <= 1'b0;
        repeat (4) @(posedge clk);
        rd(bmscc_pkg::ADDR_STAT, stat_w(1'b1, 1'b1, 1'b0, 2'h0, 1'b0));
        wr(bmscc_pkg::ADDR_CTRL, ctrl_w(2'h2, 1'b0, 1'b1, 2'h1, 1'b0));
        stat_run(4, 2, 1'b0);
        $display("test hard reset and program mode done");
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule : bmscc_top_tb
